// file: verilog/vrpsm_top.v
// control logic of a voltage-regulator power state and phase manager
// How it works
// - send ramp done packet after upward ramp
// - overshoot target few codes, then fall back
// - low-pass filter reference during downward ramp
// - inactive light-load bits: slew down at rate
// - active light-load bits: decay, step reference down
// - decay field selects trigger: never, first, both
// - full state runs all phases in CCM
// - first light-load: one synchronous phase, others tri-state
// - second light-load: one diode-emulation phase
// - ramp forces full; new state after settling
// - unforced: pick phases from current thresholds
// - four-bit hysteresis on shedding thresholds
// - ramp, window trip, phase overcurrent force full
// - per-phase on-time trim with current offset
// - 5ns base, sigma-delta fine pulse refinement
// - input voltage from divider ratio over 1024
// - below off limit: stop, tri-state outputs
// - restart when above on limit
// - on/off limits programmable, quarter-volt steps
// - latch-off mode latches on input overvoltage
// - auto-retry mode restarts below overvoltage limit
// - protection bit 7 selects overvoltage mode
// - down slew period (count plus 3) x 50ns
// - processor ramps only after supply good
`timescale 1ns/100ps
`include "vrpsm_defines.vh"
module vrpsm_top (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // processor link, pins
  input wire vid_strobe,
  input wire [7:0] vid_code,
  input wire light_load_bit_first_n,
  input wire light_load_bit_second_n,
  input wire supply_good_input,
  output reg telemetry_line,
  // configuration port
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_cmd,
  input wire [15:0] cfg_wdata,
  output reg [15:0] cfg_rdata,
  // sensed values from converters, same clock
  input wire [11:0] input_sense_pin,
  input wire [11:0] load_current,
  input wire [11:0] phase_current_0,
  input wire [11:0] phase_current_1,
  input wire [11:0] phase_current_ref,
  input wire [11:0] phase_limit,
  input wire [5:0] phase_offset_0,
  input wire [5:0] phase_offset_1,
  input wire fb_window_trip,
  // power stage control
  output reg [7:0] reference_dac,
  output reg [1:0] power_state,
  output reg [1:0] phase_enable_n,
  output reg [1:0] pulse_oe_n,
  output reg regulating,
  output reg [7:0] ontime_trim_0,
  output reg [7:0] ontime_trim_1,
  output reg [1:0] fine_pulse
);
  // ramp states
  localparam RS_IDLE = 3'd0;
  localparam RS_UP = 3'd1;
  localparam RS_FALL = 3'd2;
  localparam RS_DOWN = 3'd3;
  localparam RS_DECAY = 3'd4;
  // ramp engine overview:
  // - idle holds the reference at the last accepted target
  // - up walks one code per step period and runs past the target
  //   by a few codes, so the output lands inside its band sooner
  // - fall snaps back to the target in one clock and starts the
  //   completion packet on the telemetry line
  // - down walks one code per step period; the dac follows a
  //   low-pass copy of the reference to limit the end undershoot
  // - decay jumps the reference to the target at once and lets
  //   the load discharge the output on its own
  // a new accepted code always restarts the engine from the
  // present reference, so a late code cuts a running ramp short
  // limitation: target plus overshoot is an 8-bit sum, so a target of fc or above
  // wraps it and the ramp ends its walk early and snaps to the target with no overshoot

  // pin synchronisers
  reg [2:0] strb_s1_q, strb_s2_q;
  reg [7:0] vid_s1_q, vid_s2_q;
  reg [1:0] psi_s1_q, psi_s2_q;
  reg good_s1_q, good_s2_q;
  reg strb_prev_q;

  // configuration registers
  reg [15:0] von_q, voff_q, vov_q, shed_q, low23_q, decay_q, ratio_q, prt_q, slew_q;
  // ramp engine
  reg [2:0] rs_q;
  reg [7:0] target_q, ref_q, filt_q;
  reg [12:0] step_cnt_q;
  reg [7:0] pkt_cnt_q;
  // protection
  reg ov_latch_q;
  reg [21:0] vin_q;
  // shedding and sigma-delta accumulators
  reg [1:0] auto_ps_q;
  reg [7:0] sd_acc0_q, sd_acc1_q;

  // synchronisers: first stage read only by second stage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strb_s1_q <= 3'h0;
      strb_s2_q <= 3'h0;
      vid_s1_q <= 8'h00;
      vid_s2_q <= 8'h00;
      psi_s1_q <= 2'h3;
      psi_s2_q <= 2'h3;
      good_s1_q <= 1'b0;
      good_s2_q <= 1'b0;
      strb_prev_q <= 1'b0;
    end else begin
      strb_s1_q <= {2'h0, vid_strobe};
      strb_s2_q <= strb_s1_q;
      vid_s1_q <= vid_code;
      vid_s2_q <= vid_s1_q;
      psi_s1_q <= {light_load_bit_second_n, light_load_bit_first_n};
      psi_s2_q <= psi_s1_q;
      good_s1_q <= supply_good_input;
      good_s2_q <= good_s1_q;
      strb_prev_q <= strb_s2_q[0];
    end
  end

  wire new_cmd = strb_s2_q[0] & ~strb_prev_q & good_s2_q;
  wire psi0 = ~psi_s2_q[0];
  wire psi1 = ~psi_s2_q[1];
  // decay trigger by config field
  reg decay_ok;
  always @* begin
    case (decay_q[1:0])
      `VRPSM_DECAY_FIRST: decay_ok = psi0;
      `VRPSM_DECAY_BOTH: decay_ok = psi0 & psi1;
      default: decay_ok = 1'b0; // never decays
    endcase
  end

  // register writes and reads
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      von_q <= `VRPSM_RST_INPUT_TURN_ON_LIMIT;
      voff_q <= `VRPSM_RST_INPUT_TURN_OFF_LIMIT;
      vov_q <= `VRPSM_RST_VIN_OV;
      shed_q <= `VRPSM_RST_SHED;
      low23_q <= 16'h0000;
      decay_q <= `VRPSM_RST_DECAY;
      ratio_q <= `VRPSM_RST_RATIO;
      prt_q <= 16'h0000;
      slew_q <= `VRPSM_RST_SLEW;
      cfg_rdata <= 16'h0000;
    end else begin
      if (cfg_wr) begin
        case (cfg_cmd)
          `VRPSM_CMD_INPUT_TURN_ON_LIMIT: von_q <= cfg_wdata;
          `VRPSM_CMD_INPUT_TURN_OFF_LIMIT: voff_q <= cfg_wdata;
          `VRPSM_CMD_VIN_OV: vov_q <= cfg_wdata;
          `VRPSM_CMD_SHED: shed_q <= cfg_wdata;
          `VRPSM_CMD_LOW23: low23_q <= cfg_wdata;
          `VRPSM_CMD_DECAY: decay_q <= cfg_wdata;
          `VRPSM_CMD_RATIO: ratio_q <= cfg_wdata;
          `VRPSM_CMD_PRT: prt_q <= cfg_wdata;
          `VRPSM_CMD_SLEW: slew_q <= {5'h00, cfg_wdata[10:0]};
          default: ;
        endcase
      end
      if (cfg_rd) begin
        case (cfg_cmd)
          `VRPSM_CMD_INPUT_TURN_ON_LIMIT: cfg_rdata <= von_q;
          `VRPSM_CMD_INPUT_TURN_OFF_LIMIT: cfg_rdata <= voff_q;
          `VRPSM_CMD_VIN_OV: cfg_rdata <= vov_q;
          `VRPSM_CMD_SHED: cfg_rdata <= shed_q;
          `VRPSM_CMD_LOW23: cfg_rdata <= low23_q;
          `VRPSM_CMD_DECAY: cfg_rdata <= decay_q;
          `VRPSM_CMD_RATIO: cfg_rdata <= ratio_q;
          `VRPSM_CMD_PRT: cfg_rdata <= prt_q;
          `VRPSM_CMD_SLEW: cfg_rdata <= slew_q;
          `VRPSM_CMD_STAT: cfg_rdata <= {ov_latch_q, regulating, rs_q, power_state, auto_ps_q, target_q[6:0]};
          default: cfg_rdata <= 16'h0000; // unknown codes read zero
        endcase
      end
    end
  end

  // input voltage in quarter volts: sense * 1024 / ratio
  // the divide is combinational and wide; it is cheap enough here
  // since the sense value changes slowly, but it is the longest
  // path of the block and would be pipelined at a faster clock
  // a zero ratio is read as one, so a blank register cannot make
  // the divider produce an undefined quotient
  // only the low 16 bits of the quotient are compared; a quotient
  // above that range wraps, so the ratio must suit the divider
  wire [15:0] ratio_nz = (ratio_q == 16'h0000) ? 16'h0001 : ratio_q;
  wire [21:0] vin_full = {input_sense_pin, 10'h000} / {6'h00, ratio_nz};
  wire [15:0] vin_qv = vin_full[15:0];
  wire uv_off = vin_qv < voff_q;
  wire uv_on = vin_qv > von_q;
  wire ov_hit = vin_qv > vov_q;

  // input protection: undervoltage and overvoltage
  // shutdown wins over restart in the same clock, so a supply
  // that sits between the two limits never chatters the stage
  // the latch-off flag has no clear path: only reset ends it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regulating <= 1'b0;
      ov_latch_q <= 1'b0;
      vin_q <= 22'h000000;
    end else begin
      vin_q <= vin_full;
      if (ov_hit && !prt_q[`VRPSM_PRT_OV_RETRY])
        ov_latch_q <= 1'b1; // latch-off needs reset
      if (uv_off || ov_hit || ov_latch_q)
        regulating <= 1'b0; // stop at once
      else if (uv_on)
        regulating <= 1'b1; // restart above on limit
    end
  end

  // step period: (count + 3) steps of 50 ns
  // largest period is (2047 + 3) * 2 = 4100 clocks, inside 13 bits
  wire [12:0] step_len = ({2'h0, slew_q[10:0]} + 13'd`VRPSM_SLEW_ADD) * 13'd`VRPSM_STEP_CYC;
  wire step_tick = (step_cnt_q == 13'h0000);

  // reference ramp engine
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs_q <= RS_IDLE;
      target_q <= 8'h00;
      ref_q <= 8'h00;
      filt_q <= 8'h00;
      step_cnt_q <= 13'h0000;
      pkt_cnt_q <= 8'h00;
    end else begin
      step_cnt_q <= (step_tick || new_cmd) ? step_len - 13'd1 : step_cnt_q - 13'd1;
      // downward reference is smoothed
      filt_q <= (rs_q == RS_DOWN) ? filt_q - (filt_q >> 2) + (ref_q >> 2) : ref_q;
      pkt_cnt_q <= (pkt_cnt_q != 8'h00) ? pkt_cnt_q - 8'd1 : 8'h00;
      if (new_cmd) begin
        target_q <= vid_s2_q;
        if (vid_s2_q > ref_q)
          rs_q <= RS_UP;
        else if (vid_s2_q < ref_q)
          rs_q <= decay_ok ? RS_DECAY : RS_DOWN;
      end else begin
        case (rs_q)
          RS_UP: if (step_tick) begin
            if (ref_q >= target_q + `VRPSM_OVERSHOOT || ref_q == 8'hff)
              rs_q <= RS_FALL; // overshoot a few codes
            else
              ref_q <= ref_q + 8'd1;
          end
          RS_FALL: begin
            ref_q <= target_q;
            rs_q <= RS_IDLE;
            pkt_cnt_q <= `VRPSM_PKT_LEN; // completion packet
          end
          RS_DOWN: if (step_tick) begin
            if (ref_q <= target_q)
              rs_q <= RS_IDLE;
            else
              ref_q <= ref_q - 8'd1; // slew rate stepping
          end
          RS_DECAY: begin
            ref_q <= target_q; // dac steps straight down
            rs_q <= RS_IDLE;
          end
          default: rs_q <= RS_IDLE;
        endcase
      end
    end
  end

  // auto shedding with hysteresis
  // thresholds are six-bit fields scaled by 64 current units
  // going up in phase count needs only the plain threshold;
  // going down needs the load plus the hysteresis below it,
  // so a steady load between the two keeps the present state
  // any forcing condition overrides the load comparison and is
  // checked first, so the rail never sheds during a ramp
  wire [5:0] thr_dcm = shed_q[`VRPSM_SHED_DCM_HI:`VRPSM_SHED_DCM_LO];
  wire [5:0] thr_one = shed_q[`VRPSM_SHED_ONE_HI:0];
  wire [11:0] hyst = {8'h00, shed_q[15:`VRPSM_SHED_HYST_LO]};
  wire [11:0] one_hi = {thr_one, 6'h00};
  wire [11:0] dcm_hi = {thr_dcm, 6'h00};
  wire over_lim = (phase_current_0 > phase_limit) || (phase_current_1 > phase_limit);
  wire force_full = (rs_q != RS_IDLE) || fb_window_trip || over_lim;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      auto_ps_q <= `VRPSM_PS_FULL;
    else if (force_full)
      auto_ps_q <= `VRPSM_PS_FULL;
    else if (load_current > one_hi)
      auto_ps_q <= `VRPSM_PS_FULL; // up at once
    else if (load_current + hyst < dcm_hi)
      auto_ps_q <= `VRPSM_PS_ONEDE;
    else if (load_current + hyst < one_hi && auto_ps_q == `VRPSM_PS_FULL)
      auto_ps_q <= `VRPSM_PS_ONESYNC;
    else if (load_current > dcm_hi && auto_ps_q == `VRPSM_PS_ONEDE)
      auto_ps_q <= `VRPSM_PS_ONESYNC;
  end

  // power state selection and pin outputs
  // forced light-load bits from the processor beat the automatic
  // choice, but a running ramp beats both and keeps full phase
  // the pin enables follow the state one clock later, since they
  // are decoded from the registered state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_state <= `VRPSM_PS_FULL;
      phase_enable_n <= 2'h3;
      pulse_oe_n <= 2'h3;
      reference_dac <= 8'h00;
      telemetry_line <= 1'b0;
    end else begin
      reference_dac <= filt_q;
      telemetry_line <= (pkt_cnt_q != 8'h00);
      if (force_full)
        power_state <= `VRPSM_PS_FULL;
      else if (psi1)
        power_state <= `VRPSM_PS_ONEDE;
      else if (psi0)
        power_state <= `VRPSM_PS_ONESYNC;
      else
        power_state <= auto_ps_q;
      if (!regulating) begin
        pulse_oe_n <= 2'h3; // all tri-state
        phase_enable_n <= 2'h3;
      end else if (power_state == `VRPSM_PS_FULL) begin
        pulse_oe_n <= 2'h0;
        phase_enable_n <= 2'h0;
      end else begin
        pulse_oe_n <= 2'h2; // one phase only
        phase_enable_n <= 2'h2;
      end
    end
  end

  // current balance trim and sigma-delta fine bits
  // each trim moves one count per clock toward its own reference,
  // which is slow next to the voltage loop on purpose: the
  // balance loop must not fight the output regulation
  // trims saturate at both ends instead of wrapping
  wire [12:0] ref0 = {1'b0, phase_current_ref} + {7'h00, phase_offset_0};
  wire [12:0] ref1 = {1'b0, phase_current_ref} + {7'h00, phase_offset_1};
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ontime_trim_0 <= 8'h80;
      ontime_trim_1 <= 8'h80;
      sd_acc0_q <= 8'h00;
      sd_acc1_q <= 8'h00;
      fine_pulse <= 2'h0;
    end else begin
      if ({1'b0, phase_current_0} < ref0 && ontime_trim_0 != 8'hff)
        ontime_trim_0 <= ontime_trim_0 + 8'd1;
      else if ({1'b0, phase_current_0} > ref0 && ontime_trim_0 != 8'h00)
        ontime_trim_0 <= ontime_trim_0 - 8'd1;
      if ({1'b0, phase_current_1} < ref1 && ontime_trim_1 != 8'hff)
        ontime_trim_1 <= ontime_trim_1 + 8'd1;
      else if ({1'b0, phase_current_1} > ref1 && ontime_trim_1 != 8'h00)
        ontime_trim_1 <= ontime_trim_1 - 8'd1;
      // low bits dithered over 5 ns slots
      {fine_pulse[0], sd_acc0_q} <= {1'b0, sd_acc0_q} + {1'b0, 2'h0, ontime_trim_0[5:0]};
      {fine_pulse[1], sd_acc1_q} <= {1'b0, sd_acc1_q} + {1'b0, 2'h0, ontime_trim_1[5:0]};
    end
  end
endmodule // vrpsm_top

// file: verilog/vrpsm_defines.vh
// constants for the voltage-regulator power state and phase manager
`ifndef VRPSM_DEFINES_VH
`define VRPSM_DEFINES_VH
// register command codes
`define VRPSM_CMD_INPUT_TURN_ON_LIMIT 8'h35
`define VRPSM_CMD_INPUT_TURN_OFF_LIMIT 8'h36
`define VRPSM_CMD_VIN_OV 8'h55
`define VRPSM_CMD_SHED 8'hc7
`define VRPSM_CMD_LOW23 8'hc8
`define VRPSM_CMD_DECAY 8'hc9
`define VRPSM_CMD_RATIO 8'hd4
`define VRPSM_CMD_PRT 8'hdc
`define VRPSM_CMD_SLEW 8'h61
`define VRPSM_CMD_STAT 8'he0
// reset values (plain defaults)
`define VRPSM_RST_INPUT_TURN_ON_LIMIT 16'h0030
`define VRPSM_RST_INPUT_TURN_OFF_LIMIT 16'h0028
`define VRPSM_RST_VIN_OV 16'h0050
`define VRPSM_RST_SHED 16'h2408
`define VRPSM_RST_DECAY 16'h0001
`define VRPSM_RST_RATIO 16'h0040
`define VRPSM_RST_SLEW 16'h0000
// field positions
`define VRPSM_PRT_OV_RETRY 7
`define VRPSM_SHED_HYST_LO 12
`define VRPSM_SHED_DCM_HI 11
`define VRPSM_SHED_DCM_LO 6
`define VRPSM_SHED_ONE_HI 5
// decay modes
`define VRPSM_DECAY_NEVER 2'b00
`define VRPSM_DECAY_FIRST 2'b01
`define VRPSM_DECAY_BOTH 2'b10
// timing: 50 ns step unit at 25 ns clock
`define VRPSM_STEP_NS 50
`define VRPSM_CLK_NS 25
// clocks per 50 ns step unit, a plain number so it can follow a size prefix
`define VRPSM_STEP_CYC 2
// completion packet length in clocks
`define VRPSM_PKT_LEN 8'h08
`define VRPSM_SLEW_ADD 3
`define VRPSM_OVERSHOOT 8'h04
`define VRPSM_RATIO_SHIFT 10
`define VRPSM_VIN_FRAC 2
// power states
`define VRPSM_PS_FULL 2'b00
`define VRPSM_PS_ONESYNC 2'b01
`define VRPSM_PS_ONEDE 2'b10
`endif

// file: tb/vrpsm_top_asserts.sv
// port assertions for the power state and phase manager
`timescale 1ns/100ps
`include "vrpsm_defines.vh"
module vrpsm_top_chk (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // configuration port
  input wire cfg_rd,
  input wire [7:0] cfg_cmd,
  input wire [15:0] cfg_rdata,
  // sensed levels
  input wire [11:0] phase_current_0,
  input wire [11:0] phase_limit,
  input wire fb_window_trip,
  // watched outputs
  input wire telemetry_line,
  input wire regulating,
  input wire [1:0] power_state,
  input wire [1:0] pulse_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // completion packet: eight cycles high, then low
  sequence pkt_shape; telemetry_line [*8] ##1 !telemetry_line; endsequence
  // two edges in a state, so a one-cycle skew between registers is allowed
  sequence full_held; (regulating && power_state == `VRPSM_PS_FULL) [*2]; endsequence
  sequence light_held; (regulating && power_state != `VRPSM_PS_FULL) [*2]; endsequence
  sequence stop_held; (!regulating) [*2]; endsequence
  pkt_len_a: assert property ($rose(telemetry_line) |-> pkt_shape)
    else $error("completion packet length wrong");
  stop_tristate_a: assert property (stop_held |-> pulse_oe_n == 2'b11)
    else $error("pulse outputs driven while stopped");
  full_ccm_a: assert property (full_held |-> pulse_oe_n == 2'b00)
    else $error("phase idle in full state");
  light_single_a: assert property (light_held |-> $onehot(~pulse_oe_n))
    else $error("light state not single phase");
  trip_full_a: assert property (fb_window_trip && regulating |-> ##[1:3] power_state == `VRPSM_PS_FULL)
    else $error("window trip kept shedding");
  phase_ocp_full_a: assert property (phase_current_0 > phase_limit && regulating
    |-> ##[1:3] power_state == `VRPSM_PS_FULL)
    else $error("phase overcurrent kept shedding");
  bad_read_a: assert property (cfg_rd && cfg_cmd == 8'h00 |=> cfg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without read");
endmodule // vrpsm_top_chk
bind vrpsm_top vrpsm_top_chk chk (.clk(clk), .reset_n(reset_n), .cfg_rd(cfg_rd), .cfg_cmd(cfg_cmd),
  .cfg_rdata(cfg_rdata), .phase_current_0(phase_current_0), .phase_limit(phase_limit),
  .fb_window_trip(fb_window_trip), .telemetry_line(telemetry_line), .regulating(regulating),
  .power_state(power_state), .pulse_oe_n(pulse_oe_n));

// file: tb/vrpsm_cpu_model.sv
// processor side model: sends codes and light-load bits over the link pins
`timescale 1ns/100ps
module vrpsm_cpu_model (
  // link pins
  output logic vid_strobe,
  output logic [7:0] vid_code,
  output logic light_load_bit_first_n,
  output logic light_load_bit_second_n,
  output logic supply_good_input
);
  // link idle, supply good low until the bench raises it
  initial begin
    vid_strobe = 1'b0;
    vid_code = 8'h00;
    light_load_bit_first_n = 1'b1;
    light_load_bit_second_n = 1'b1;
    supply_good_input = 1'b0;
  end
  // one frame: strobe high for 100 ns, with the code stable 100 ns before and after it
  task send(input logic [7:0] c, input logic [1:0] ll_n);
    vid_code = c;
    {light_load_bit_second_n, light_load_bit_first_n} = ll_n;
    #100 vid_strobe = 1'b1;
    #100 vid_strobe = 1'b0;
    // hold time over: code no longer valid, so show its inverse
    #100 vid_code = ~c;
  endtask
endmodule // vrpsm_cpu_model

// file: tb/vrpsm_top_tb.sv
// self-checking bench for the power state and phase manager
`timescale 1ns/100ps
`include "vrpsm_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < n) begin @(negedge clk); k++; end n_checks++; if (!(c)) tmo; end
module vrpsm_top_tb;
  // driven inputs
  logic clk, reset_n, cfg_wr, cfg_rd, fb_window_trip;
  logic [7:0] cfg_cmd;
  logic [15:0] cfg_wdata;
  logic [11:0] input_sense_pin, load_current, phase_current_0, phase_limit;
  // link pins and outputs
  wire vid_strobe, light_load_bit_first_n, light_load_bit_second_n, supply_good_input;
  wire telemetry_line, regulating;
  wire [7:0] vid_code, reference_dac, ontime_trim_0;
  wire [15:0] cfg_rdata;
  wire [1:0] power_state;
  int error_cnt, n_checks, k;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  vrpsm_cpu_model cpu (.vid_strobe(vid_strobe), .vid_code(vid_code),
    .light_load_bit_first_n(light_load_bit_first_n), .light_load_bit_second_n(light_load_bit_second_n),
    .supply_good_input(supply_good_input));
  // current balance references and phase 1 tied: only ontime_trim_0 is judged, at the end
  vrpsm_top uut (.clk(clk), .reset_n(reset_n), .vid_strobe(vid_strobe), .vid_code(vid_code),
    .light_load_bit_first_n(light_load_bit_first_n), .light_load_bit_second_n(light_load_bit_second_n),
    .supply_good_input(supply_good_input), .telemetry_line(telemetry_line), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_cmd(cfg_cmd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .input_sense_pin(input_sense_pin), .load_current(load_current), .phase_current_0(phase_current_0),
    .phase_current_1(12'h000), .phase_current_ref(12'h000), .phase_limit(phase_limit),
    .phase_offset_0(6'h00), .phase_offset_1(6'h00), .fb_window_trip(fb_window_trip),
    .reference_dac(reference_dac), .power_state(power_state), .phase_enable_n(), .pulse_oe_n(),
    .regulating(regulating), .ontime_trim_0(ontime_trim_0), .ontime_trim_1(), .fine_pulse());
  // verdict and stop
  task end_sim;
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a bounded wait ran out
  task tmo;
    error_cnt++;
    $display("ERROR %0t: wait timed out", $time);
    end_sim;
  endtask
  // one-cycle write pulse
  task wr(input logic [7:0] c, input logic [15:0] d);
    cfg_cmd = c;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk) cfg_wr = 1'b0;
    @(negedge clk);
  endtask
  // read pulse, data taken once it stands
  task rd(input logic [7:0] c, output logic [15:0] d);
    cfg_cmd = c;
    cfg_rd = 1'b1;
    @(negedge clk) cfg_rd = 1'b0;
    @(negedge clk) d = cfg_rdata;
  endtask
  // reset values, write-back and an unmapped read
  task s_regs;
    logic [15:0] d;
    rd(`VRPSM_CMD_INPUT_TURN_ON_LIMIT, d);
    `CHK(d, `VRPSM_RST_INPUT_TURN_ON_LIMIT)
    rd(`VRPSM_CMD_INPUT_TURN_OFF_LIMIT, d);
    `CHK(d, `VRPSM_RST_INPUT_TURN_OFF_LIMIT)
    rd(`VRPSM_CMD_VIN_OV, d);
    `CHK(d, `VRPSM_RST_VIN_OV)
    rd(`VRPSM_CMD_RATIO, d);
    `CHK(d, `VRPSM_RST_RATIO)
    wr(`VRPSM_CMD_DECAY, 16'h0002);
    rd(`VRPSM_CMD_DECAY, d);
    `CHK(d, 16'h0002)
    rd(8'h00, d);
    `CHK(d, 16'h0000)
  endtask
  // refused while supply good low, then an up ramp with overshoot
  task s_up;
    logic [7:0] mx;
    cpu.send(8'h20, 2'b11);
    repeat (20) @(negedge clk);
    `CHK(reference_dac, 8'h00)
    cpu.supply_good_input = 1'b1;
    cpu.send(8'h20, 2'b11);
    mx = 8'h00;
    for (k = 0; k < 3000 && telemetry_line !== 1'b1; k++) begin
      @(negedge clk);
      if (reference_dac > mx) mx = reference_dac;
    end
    `CHK(telemetry_line, 1'b1)
    `CHK(mx, 8'h20 + `VRPSM_OVERSHOOT)
    repeat (40) @(negedge clk);
    `CHK(reference_dac, 8'h20)
  endtask
  // light load sheds, window trip and phase overcurrent restore full
  task s_force;
    load_current = 12'h000;
    `WAITC(power_state === `VRPSM_PS_ONEDE, 400)
    fb_window_trip = 1'b1;
    `WAITC(power_state === `VRPSM_PS_FULL, 3)
    fb_window_trip = 1'b0;
    `WAITC(power_state === `VRPSM_PS_ONEDE, 400)
    phase_current_0 = 12'hfff;
    `WAITC(power_state === `VRPSM_PS_FULL, 3)
    phase_current_0 = 12'h100;
    load_current = 12'hfff;
  endtask
  // downward step: decay jumps, slewing takes many step periods
  task dn(input logic [1:0] m, input logic [7:0] c, input logic [1:0] ll, input logic f, input logic [1:0] ps);
    wr(`VRPSM_CMD_DECAY, {14'h0000, m});
    cpu.send(c, ll);
    repeat (12) @(negedge clk);
    `CHK(reference_dac === c, f)
    `WAITC(reference_dac === c, 800)
    `WAITC(power_state === ps, 400)
  endtask
  // input under and over voltage; 1 sense lsb is 16 quarter volts at ratio 40h
  task s_vin;
    input_sense_pin = 12'h001;
    `WAITC(regulating === 1'b0, 50)
    input_sense_pin = 12'h004;
    `WAITC(regulating === 1'b1, 50)
    wr(`VRPSM_CMD_RATIO, 16'h0080);
    `WAITC(regulating === 1'b0, 50)
    wr(`VRPSM_CMD_RATIO, `VRPSM_RST_RATIO);
    `WAITC(regulating === 1'b1, 50)
    wr(`VRPSM_CMD_PRT, 16'h0080);
    input_sense_pin = 12'h006;
    `WAITC(regulating === 1'b0, 50)
    input_sense_pin = 12'h004;
    `WAITC(regulating === 1'b1, 50)
    wr(`VRPSM_CMD_PRT, 16'h0000);
    input_sense_pin = 12'h006;
    `WAITC(regulating === 1'b0, 50)
    input_sense_pin = 12'h004;
    repeat (50) @(negedge clk);
    `CHK(regulating, 1'b0)
  endtask
  // main sequence; latch-off case last since only reset clears it
  initial begin
    {clk, reset_n, cfg_wr, cfg_rd, fb_window_trip} = 5'h00;
    {cfg_cmd, cfg_wdata} = 24'h000000;
    input_sense_pin = 12'h004;
    load_current = 12'hfff;
    phase_current_0 = 12'h100;
    phase_limit = 12'h800;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    s_regs;
    s_up;
    s_force;
    dn(`VRPSM_DECAY_FIRST, 8'h18, 2'b10, 1'b1, `VRPSM_PS_ONESYNC);
    dn(`VRPSM_DECAY_NEVER, 8'h10, 2'b10, 1'b0, `VRPSM_PS_ONESYNC);
    dn(`VRPSM_DECAY_BOTH, 8'h08, 2'b10, 1'b0, `VRPSM_PS_ONESYNC);
    dn(`VRPSM_DECAY_BOTH, 8'h02, 2'b00, 1'b1, `VRPSM_PS_ONEDE);
    s_vin;
    // phase 0 current stayed above its zero reference all run
    `CHK(ontime_trim_0, 8'h00)
    end_sim;
  end
endmodule // vrpsm_top_tb
